// *** include/wcw_consts.vh ***
// constants for the write-once configuration and watchdog block
`ifndef WCW_CONSTS_VH
`define WCW_CONSTS_VH

// register indices; byte address is four times the index
`define WCW_IDX_CFG_B 16'h001e
`define WCW_IDX_CFG_A 16'h001f
`define WCW_IDX_SERVICE 16'hffff
`define WCW_IDX_CAUSE 16'h0001

// option_config_b fields
`define WCW_B_TB_DIV128 3
`define WCW_B_OSC_RUN 1
`define WCW_B_BAUD_SRC 0
`define WCW_CFG_B_RST 8'h01
`define WCW_CFG_B_MASK 8'h0b

// option_config_a fields
`define WCW_A_WD_RATE 7
`define WCW_A_LV_STOP 6
`define WCW_A_LV_RSTD 5
`define WCW_A_LV_PWRD 4
`define WCW_A_LV_TRIP 3
`define WCW_A_SHORT_STOP_RECOVERY 2
`define WCW_A_STOP_EN 1
`define WCW_A_WD_DIS 0
`define WCW_CFG_A_RST 8'h00

// reset cause fields
`define WCW_C_WD 0

// timing counts in oscillator cycles
`define WCW_WD_LONG 18'd262128
`define WCW_WD_SHORT 18'd8176
`define WCW_WD_PULSE 13'd32
`define WCW_REC_SHORT 13'd32
`define WCW_REC_LONG 13'd4096
`define WCW_POR_DELAY 13'd4096

`endif

// *** rtl/wcw_config_watchdog.v ***
// write-once option registers and watchdog behind a classic wishbone slave
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
// Summary of operation
// - each option register takes one write per reset, readable always
// - trip mode bit cleared only by power-on reset, written once per power-on
// - timebase select bit inserts extra divide-by-128 prescaler
// - oscillator runs in stop only when run-in-stop bit set
// - baud source bit: 1 bus clock (default), 0 oscillator clock
// - rate bit: 8176 cycles when 1, 262128 when 0, reset clears
// - low-voltage stop enable keeps monitor running in stop unless powered down
// - low-voltage reset disable bit suppresses monitor resets
// - low-voltage power down bit powers the monitor off
// - stop recovery 32 cycles when short bit set, else 4096
// - stop exit by low-voltage reset always uses long recovery
// - stop instruction illegal when stop enable clear, else enters stop
// - watchdog disable bit 1 disables, 0 (reset) enables watchdog
// - 6-bit counter after 12-bit prescaler; overflow requests reset
// - service write clears counter and prescaler stages 12 to 5
// - service read returns reset vector low byte, no clear
// - watchdog reset drives reset pin low 32 cycles, sets cause flag
// - internal reset clears all; stop and vector fetch clear prescaler
// - power-on clears prescaler after 4096 oscillator cycles
// - test voltage on either pin in monitor, or on reset pin in break, disables watchdog
// - stop gates oscillator from watchdog and clears prescaler; wait keeps it
`include "wcw_consts.vh"

module wcw_config_watchdog (
    input wire clk_i,
    input wire rst_i,
    input wire por_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [17:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire osc_tick_i,
    input wire [7:0] reset_vec_lo_i,
    input wire stop_instr_i,
    input wire wake_i,
    input wire wake_by_lvm_i,
    input wire vector_fetch_i,
    input wire monitor_mode_i,
    input wire break_i,
    input wire rst_pin_tst_i,
    input wire irq_pin_tst_i,
    input wire lvm_reset_req_i,
    output reg rst_pin_o,
    output reg rst_pin_oe_o,
    output reg wd_reset_o,
    output reg illegal_opcode_o,
    output reg stop_mode_o,
    output reg stop_done_o,
    output reg osc_run_o,
    output reg timebase_div128_o,
    output reg serial_baud_clock_source_o,
    output reg low_volt_trip_mode_o,
    output reg low_volt_power_o,
    output reg low_volt_stop_run_o,
    output reg low_volt_reset_o
);

////////////////////////////////////////////////////////////////////////////////
// state
localparam [2:0] ST_RUN = 3'b001;
localparam [2:0] ST_STOP = 3'b010;
localparam [2:0] ST_RECOVER = 3'b100;

reg [7:0] cfg_a_ff;
reg [7:0] cfg_b_ff;
reg cfg_a_done_ff;
reg cfg_b_done_ff;
reg trip_ff;
reg trip_done_ff;
reg cause_wd_ff;
reg [17:0] chain_ff;
reg [12:0] pulse_cnt_ff;
reg [12:0] rec_cnt_ff;
reg [12:0] rec_len_ff;
reg [12:0] por_cnt_ff;
reg por_wait_ff;
reg [2:0] state_ff;

reg [2:0] nxt_state;
reg [17:0] nxt_chain;
reg wd_overflow;

////////////////////////////////////////////////////////////////////////////////
// bus decode
wire [15:0] idx = adr_i[17:2];
wire req = cyc_i && stb_i && !ack_o;
wire wr_b0 = req && we_i && sel_i[0];
wire rd = req && !we_i;
wire hit_a = idx == `WCW_IDX_CFG_A;
wire hit_b = idx == `WCW_IDX_CFG_B;
wire hit_srv = idx == `WCW_IDX_SERVICE;
wire hit_cause = idx == `WCW_IDX_CAUSE;

function [7:0] read_mux;
    input [15:0] f_idx;
    begin
        case (f_idx)
            `WCW_IDX_CFG_A: read_mux = {cfg_a_ff[7:4], trip_ff, cfg_a_ff[2:0]};
            `WCW_IDX_CFG_B: read_mux = cfg_b_ff;
            `WCW_IDX_SERVICE: read_mux = reset_vec_lo_i;
            `WCW_IDX_CAUSE: read_mux = {7'h00, cause_wd_ff};
            default: read_mux = 8'h00;
        endcase
    end
endfunction

// ack one cycle after the request; the !ack_o term stops a second ack
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
    end else begin
        ack_o <= req;
        if (rd) begin
            dat_o <= {24'h000000, read_mux(idx)};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// option registers
wire svc_wr = req && we_i && hit_srv;
wire wd_rate = cfg_a_ff[`WCW_A_WD_RATE];
wire wd_dis_bit = cfg_a_ff[`WCW_A_WD_DIS];
wire lv_pwrd = cfg_a_ff[`WCW_A_LV_PWRD];

always @(posedge clk_i) begin
    if (rst_i) begin
        cfg_a_ff <= `WCW_CFG_A_RST;
        cfg_b_ff <= `WCW_CFG_B_RST;
        cfg_a_done_ff <= 1'b0;
        cfg_b_done_ff <= 1'b0;
    end else begin
        if (wr_b0 && hit_a && !cfg_a_done_ff) begin
            cfg_a_ff <= dat_i[7:0];
            cfg_a_done_ff <= 1'b1;
        end
        if (wr_b0 && hit_b && !cfg_b_done_ff) begin
            cfg_b_ff <= dat_i[7:0] & `WCW_CFG_B_MASK;
            cfg_b_done_ff <= 1'b1;
        end
    end
end

// trip mode lives across ordinary resets
always @(posedge clk_i) begin
    if (por_i) begin
        trip_ff <= 1'b0;
        trip_done_ff <= 1'b0;
    end else if (!rst_i && wr_b0 && hit_a && !trip_done_ff) begin
        trip_ff <= dat_i[`WCW_A_LV_TRIP];
        trip_done_ff <= 1'b1;
    end
end

// an overflow in a reset cycle is dropped, the chain is being cleared then
wire wd_fire = wd_overflow && !rst_i;

// watchdog cause survives ordinary resets; set wins over read clear
always @(posedge clk_i) begin
    if (por_i) begin
        cause_wd_ff <= 1'b0;
    end else if (wd_fire) begin
        cause_wd_ff <= 1'b1;
    end else if (!rst_i && rd && hit_cause) begin
        cause_wd_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// stop mode sequencing
wire stop_en = cfg_a_ff[`WCW_A_STOP_EN];
wire stop_go = stop_instr_i && stop_en && state_ff == ST_RUN;
wire rec_end = state_ff == ST_RECOVER && osc_tick_i && rec_cnt_ff == rec_len_ff - 13'd1;

always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_RUN: begin
            if (stop_go) begin
                nxt_state = ST_STOP;
            end
        end
        ST_STOP: begin
            if (wake_i || wake_by_lvm_i) begin
                nxt_state = ST_RECOVER;
            end
        end
        ST_RECOVER: begin
            if (rec_end) begin
                nxt_state = ST_RUN;
            end
        end
        default: nxt_state = ST_RUN;
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        state_ff <= ST_RUN;
        rec_cnt_ff <= 13'd0;
        rec_len_ff <= `WCW_REC_LONG;
        illegal_opcode_o <= 1'b0;
        stop_done_o <= 1'b0;
        stop_mode_o <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        illegal_opcode_o <= stop_instr_i && !stop_en && state_ff == ST_RUN;
        stop_done_o <= rec_end;
        stop_mode_o <= nxt_state != ST_RUN;
        // length follows the wake cause seen on the wake cycle itself
        if (state_ff == ST_STOP) begin
            rec_cnt_ff <= 13'd0;
            if (cfg_a_ff[`WCW_A_SHORT_STOP_RECOVERY] && !wake_by_lvm_i) begin
                rec_len_ff <= `WCW_REC_SHORT;
            end else begin
                rec_len_ff <= `WCW_REC_LONG;
            end
        end else if (state_ff == ST_RECOVER && osc_tick_i) begin
            rec_cnt_ff <= rec_cnt_ff + 13'd1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// power-on prescaler clear
// runs from power-up only; ordinary resets leave the timer alone
wire por_clear = por_wait_ff && osc_tick_i && por_cnt_ff == `WCW_POR_DELAY - 13'd1;

always @(posedge clk_i) begin
    if (por_i) begin
        por_wait_ff <= 1'b1;
        por_cnt_ff <= 13'd0;
    end else if (por_wait_ff && osc_tick_i) begin
        por_cnt_ff <= por_cnt_ff + 13'd1;
        if (por_clear) begin
            por_wait_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// watchdog chain: bits 11:0 prescaler, 17:12 counter
// test voltage on a pin overrides a clear disable bit
wire tst_block = (monitor_mode_i && (rst_pin_tst_i || irq_pin_tst_i))
    || (break_i && rst_pin_tst_i);
wire wd_off = wd_dis_bit || tst_block;
wire wd_tick = osc_tick_i && state_ff == ST_RUN;
wire pre_clear = (state_ff == ST_RUN && stop_instr_i) || vector_fetch_i || por_clear;
wire [17:0] wd_limit = wd_rate ? `WCW_WD_SHORT : `WCW_WD_LONG;

always @* begin
    nxt_chain = chain_ff;
    wd_overflow = 1'b0;
    if (wd_off) begin
        nxt_chain = 18'h00000;
    end else begin
        if (wd_tick) begin
            nxt_chain = chain_ff + 18'h00001;
            // compare with >= so a late switch to the short rate cannot run past it
            if (nxt_chain >= wd_limit) begin
                wd_overflow = 1'b1;
                nxt_chain = 18'h00000;
            end
        end
        // stages 4 to 1 survive, so the next timeout may be up to 15 ticks short
        if (svc_wr) begin
            nxt_chain = {14'h0000, nxt_chain[3:0]};
        end
        if (pre_clear || state_ff != ST_RUN) begin
            nxt_chain = {nxt_chain[17:12], 12'h000};
        end
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        chain_ff <= 18'h00000;
    end else begin
        chain_ff <= nxt_chain;
    end
end

////////////////////////////////////////////////////////////////////////////////
// reset pin pulse, kept through the reset it causes
always @(posedge clk_i) begin
    if (por_i) begin
        pulse_cnt_ff <= 13'd0;
        rst_pin_oe_o <= 1'b0;
        wd_reset_o <= 1'b0;
    end else if (wd_fire) begin
        pulse_cnt_ff <= `WCW_WD_PULSE;
        rst_pin_oe_o <= 1'b1;
        wd_reset_o <= 1'b1;
    end else if (pulse_cnt_ff != 13'd0) begin
        if (osc_tick_i) begin
            pulse_cnt_ff <= pulse_cnt_ff - 13'd1;
            if (pulse_cnt_ff == 13'd1) begin
                rst_pin_oe_o <= 1'b0;
                wd_reset_o <= 1'b0;
            end
        end
    end
end

always @(posedge clk_i) begin
    rst_pin_o <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// option outputs
always @(posedge clk_i) begin
    if (rst_i) begin
        osc_run_o <= 1'b1;
        timebase_div128_o <= 1'b0;
        serial_baud_clock_source_o <= 1'b1;
        low_volt_trip_mode_o <= 1'b0;
        low_volt_power_o <= 1'b1;
        low_volt_stop_run_o <= 1'b0;
        low_volt_reset_o <= 1'b0;
    end else begin
        // recovery counts osc ticks, so the oscillator halts only in stop proper
        osc_run_o <= nxt_state != ST_STOP || cfg_b_ff[`WCW_B_OSC_RUN];
        timebase_div128_o <= cfg_b_ff[`WCW_B_TB_DIV128];
        serial_baud_clock_source_o <= cfg_b_ff[`WCW_B_BAUD_SRC];
        low_volt_trip_mode_o <= trip_ff;
        low_volt_power_o <= !lv_pwrd;
        low_volt_stop_run_o <= cfg_a_ff[`WCW_A_LV_STOP] && !lv_pwrd;
        low_volt_reset_o <= lvm_reset_req_i && !cfg_a_ff[`WCW_A_LV_RSTD];
    end
end

endmodule // wcw_config_watchdog

// *** tb/wcw_config_watchdog_sva.sv ***
// assertions for the option registers and watchdog
`timescale 1ns/100ps
module wcw_config_watchdog_sva (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [17:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire [7:0] reset_vec_lo_i,
    input wire stop_instr_i,
    input wire lvm_reset_req_i,
    input wire rst_pin_o,
    input wire rst_pin_oe_o,
    input wire wd_reset_o,
    input wire illegal_opcode_o,
    input wire stop_mode_o,
    input wire stop_done_o,
    input wire low_volt_power_o,
    input wire low_volt_stop_run_o,
    input wire low_volt_reset_o
);
    logic [5:0] hi_cnt_ff;
    // length of the current reset pulse
    always @(posedge clk_i) begin
        hi_cnt_ff <= wd_reset_o ? hi_cnt_ff + 6'h01 : 6'h00;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_bus_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_service_read: assert property (ack_o && !we_i && adr_i == 18'h3fffc
        |-> dat_o == {24'h000000, reset_vec_lo_i})
        else $error("service read not vector byte");
    a_illegal_cause: assert property (illegal_opcode_o |-> $past(stop_instr_i) && !stop_mode_o)
        else $error("illegal opcode without stop");
    a_stop_cause: assert property ($rose(stop_mode_o) |-> $past(stop_instr_i))
        else $error("stop entered without instruction");
    a_stop_leave: assert property (stop_done_o |=> !stop_mode_o)
        else $error("stop held after recovery");
    a_pin_drive: assert property (wd_reset_o |-> rst_pin_oe_o && !rst_pin_o)
        else $error("reset pin not pulled low");
    a_pulse_len: assert property ($fell(wd_reset_o) |-> hi_cnt_ff == 6'd32)
        else $error("reset pulse not 32 cycles");
    a_lv_gate: assert property (low_volt_stop_run_o |-> low_volt_power_o)
        else $error("monitor runs in stop while off");
    a_lv_pass: assert property (low_volt_reset_o |-> $past(lvm_reset_req_i))
        else $error("monitor reset without request");
endmodule // wcw_config_watchdog_sva
bind wcw_config_watchdog wcw_config_watchdog_sva chk_u (.*);

// *** tb/wcw_config_watchdog_tb.sv ***
// self-checking bench for the option registers and watchdog
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module wcw_config_watchdog_tb;
    localparam logic [17:0] CA = 18'h0007c, CB = 18'h00078;
    localparam logic [17:0] SVC = 18'h3fffc, CAUSE = 18'h00004;
    logic clk_i, rst_i, por_i, cyc_i, stb_i, we_i, osc_tick_i, stop_instr_i, wake_i;
    logic wake_by_lvm_i, vector_fetch_i, monitor_mode_i, break_i, rst_pin_tst_i;
    logic irq_pin_tst_i, lvm_reset_req_i, ack_o, rst_pin_o, rst_pin_oe_o, wd_reset_o;
    logic illegal_opcode_o, stop_mode_o, stop_done_o, osc_run_o, timebase_div128_o;
    logic serial_baud_clock_source_o, low_volt_trip_mode_o, low_volt_power_o;
    logic low_volt_stop_run_o, low_volt_reset_o;
    logic [17:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [7:0] reset_vec_lo_i, rdat;
    int miscompares, total_checks, n;
    wcw_config_watchdog dut_u (.*);
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdat = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic stop_rec(input logic lvm, input int exp);
        acc(1'b1, SVC, 8'h00);
        stop_instr_i <= 1'b1;
        @(posedge clk_i);
        stop_instr_i <= 1'b0;
        @(posedge clk_i);
        `CHK(stop_mode_o, 1'b1)
        `CHK(osc_run_o, 1'b1)
        wake_by_lvm_i <= lvm;
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        n = 0;
        while (stop_done_o !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= exp - 1 && n <= exp + 3, 1'b1)
        wake_by_lvm_i <= 1'b0;
    endtask
    initial begin
        #2400000;
        miscompares++;
        wrap_up;
    end
    initial begin
        {cyc_i, stb_i, we_i, stop_instr_i, wake_i, wake_by_lvm_i, vector_fetch_i} = 7'h00;
        {monitor_mode_i, break_i, rst_pin_tst_i, irq_pin_tst_i, lvm_reset_req_i} = 5'h00;
        {rst_i, por_i, osc_tick_i} = 3'h7;
        adr_i = 18'h00000;
        sel_i = 4'h1;
        dat_i = 32'h00000000;
        reset_vec_lo_i = 8'h5a;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        acc(1'b0, CA, 8'h00);
        `CHK(rdat, 8'h00)
        acc(1'b0, CB, 8'h00);
        `CHK(rdat, 8'h01)
        acc(1'b1, CA, 8'h8e);
        acc(1'b1, CA, 8'hff);
        acc(1'b0, CA, 8'h00);
        `CHK(rdat, 8'h8e)
        acc(1'b1, CB, 8'h0a);
        acc(1'b1, CB, 8'hf5);
        acc(1'b0, CB, 8'h00);
        `CHK(rdat, 8'h0a)
        `CHK({timebase_div128_o, serial_baud_clock_source_o, low_volt_trip_mode_o,
            low_volt_power_o, low_volt_stop_run_o}, 5'b10110)
        acc(1'b0, SVC, 8'h00);
        `CHK(rdat, 8'h5a)
        lvm_reset_req_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK(low_volt_reset_o, 1'b1)
        lvm_reset_req_i <= 1'b0;
        stop_rec(1'b0, 32);
        stop_rec(1'b1, 4096);
        acc(1'b1, SVC, 8'h00);
        monitor_mode_i <= 1'b1;
        irq_pin_tst_i <= 1'b1;
        repeat (9000) @(posedge clk_i);
        `CHK(wd_reset_o, 1'b0)
        {monitor_mode_i, irq_pin_tst_i, break_i, rst_pin_tst_i} <= 4'h3;
        repeat (9000) @(posedge clk_i);
        `CHK(wd_reset_o, 1'b0)
        acc(1'b0, CAUSE, 8'h00);
        `CHK(rdat, 8'h00)
        {break_i, rst_pin_tst_i} <= 2'h0;
        repeat (1000) @(posedge clk_i);
        acc(1'b1, SVC, 8'h33);
        n = 0;
        while (wd_reset_o !== 1'b1 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= 8160 && n <= 8176, 1'b1)
        `CHK({rst_pin_oe_o, rst_pin_o}, 2'b10)
        repeat (40) @(posedge clk_i);
        acc(1'b0, CAUSE, 8'h00);
        `CHK(rdat[0], 1'b1)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b0, CA, 8'h00);
        `CHK(rdat, 8'h08)
        acc(1'b1, CA, 8'h81);
        stop_instr_i <= 1'b1;
        @(posedge clk_i);
        stop_instr_i <= 1'b0;
        @(posedge clk_i);
        `CHK(illegal_opcode_o, 1'b1)
        repeat (9000) @(posedge clk_i);
        `CHK(wd_reset_o, 1'b0)
        acc(1'b0, CAUSE, 8'h00);
        `CHK(rdat, 8'h00)
        wrap_up;
    end
endmodule // wcw_config_watchdog_tb
